// *** core/break_controller_pkg.sv ***
// constants, encodings and carriers shared by the break controller files
`default_nettype none
package break_controller_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_A_ADDR   = 8'h00;
    localparam logic [7:0] ADDR_A_AMASK  = 8'h04;
    localparam logic [7:0] ADDR_A_DATA   = 8'h08;
    localparam logic [7:0] ADDR_A_DMASK  = 8'h0c;
    localparam logic [7:0] ADDR_A_CYCLE  = 8'h10;
    localparam logic [7:0] ADDR_B_ADDR   = 8'h14;
    localparam logic [7:0] ADDR_B_AMASK  = 8'h18;
    localparam logic [7:0] ADDR_B_DATA   = 8'h1c;
    localparam logic [7:0] ADDR_B_DMASK  = 8'h20;
    localparam logic [7:0] ADDR_B_CYCLE  = 8'h24;
    localparam logic [7:0] ADDR_CTRL     = 8'h28;
    localparam logic [7:0] ADDR_REP_SET  = 8'h2c;
    localparam logic [7:0] ADDR_REP_CNT  = 8'h30;
    localparam logic [7:0] ADDR_INT_STAT = 8'h34;
    localparam logic [7:0] ADDR_INT_MASK = 8'h38;
    // branch buffer window: base + 8*entry, +4 selects destination
    localparam logic [1:0] ADDR_BRBUF_HI = 2'h1;

    // control register fields
    localparam int CTRL_SEQ_BIT     = 0;
    localparam int CTRL_TIMING_B    = 6;
    localparam int CTRL_DATA_EN_A   = 7;
    localparam int CTRL_TIMING_A    = 10;
    localparam int CTRL_TRACE_BIT   = 11;
    localparam int CTRL_FLAG_B_BIT  = 12;

    // cycle condition register fields
    localparam int CYC_CTYPE_LSB    = 0;
    localparam int CYC_DIR_LSB      = 2;
    localparam int CYC_SIZE_LSB     = 4;
    localparam int CYC_ASRC_BIT     = 6;
    localparam int CYC_DSRC_BIT     = 7;
    localparam int CYC_DATA_EN_BIT  = 8;

    // interrupt status bits
    localparam int INT_BREAK_A      = 0;
    localparam int INT_BREAK_B      = 1;
    localparam int INT_FLAG_B       = 2;
    localparam int INT_W            = 3;

    localparam int REP_W            = 12;
    localparam int BRBUF_DEPTH      = 4;

    // cycle type: bit0 allows fetch, bit1 allows data access
    localparam logic [1:0] CTYPE_FETCH = 2'h1;
    localparam logic [1:0] CTYPE_DATA  = 2'h2;
    // direction: bit0 allows read, bit1 allows write
    localparam logic [1:0] DIR_READ    = 2'h1;
    localparam logic [1:0] DIR_WRITE   = 2'h2;
    // operand size
    localparam logic [1:0] SIZE_ANY    = 2'h0;
    localparam logic [1:0] SIZE_BYTE   = 2'h1;
    localparam logic [1:0] SIZE_WORD   = 2'h2;
    localparam logic [1:0] SIZE_LONG   = 2'h3;

    // one observed processor bus cycle
    typedef struct packed {
        logic        valid;
        logic        on_ibus;
        logic        fetch;
        logic        write;
        logic [1:0]  size;
        logic [31:0] local_addr_bus;
        logic [31:0] internal_addr_bus;
        logic [31:0] local_data_bus;
        logic [31:0] internal_data_bus;
    } bus_cycle_s;

    // one taken branch
    typedef struct packed {
        logic        valid;
        logic [31:0] src;
        logic [31:0] dst;
    } branch_s;

    // per-channel break condition
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] amask;
        logic [31:0] data;
        logic [31:0] dmask;
        logic        data_en;
        logic        dsrc;
        logic        asrc;
        logic [1:0]  size;
        logic [1:0]  dir;
        logic [1:0]  ctype;
    } chan_cfg_s;

    // break request to the exception logic
    typedef struct packed {
        logic req;
        logic after;
        logic chan_b;
    } break_s;

endpackage
`default_nettype wire

// *** core/chan_match.sv ***
// one break comparison channel: address, data and bus cycle match
`default_nettype none
module chan_match
    import break_controller_pkg::*;
(
    // condition and observed cycle
    input  wire chan_cfg_s  i_cfg,
    input  wire bus_cycle_s i_cyc,
    // result
    output logic            o_match
);
    logic [31:0] addr_sel;
    logic [31:0] data_sel;
    logic        addr_ok;
    logic        data_ok;
    logic        type_ok;
    logic        dir_ok;
    logic        size_ok;
    logic        bus_ok;

    always_comb begin
        addr_sel = i_cfg.asrc ? i_cyc.internal_addr_bus : i_cyc.local_addr_bus;
        data_sel = i_cfg.dsrc ? i_cyc.internal_data_bus : i_cyc.local_data_bus;
        addr_ok  = ((addr_sel ^ i_cfg.addr) & ~i_cfg.amask) == 32'h0000_0000;
        data_ok  = !i_cfg.data_en
                   || (((data_sel ^ i_cfg.data) & ~i_cfg.dmask) == 32'h0000_0000);
        type_ok  = i_cyc.fetch ? i_cfg.ctype[0] : i_cfg.ctype[1];
        dir_ok   = i_cyc.write ? i_cfg.dir[1] : i_cfg.dir[0];
        size_ok  = (i_cfg.size == SIZE_ANY) || (i_cfg.size == i_cyc.size);
        bus_ok   = i_cyc.on_ibus == i_cfg.asrc;
        // all enabled terms in the same cycle
        o_match  = i_cyc.valid && addr_ok && data_ok && type_ok
                   && dir_ok && size_ok && bus_ok;
    end
endmodule
`default_nettype wire

// *** core/break_controller.sv ***
// break controller top: registers, sequencing, repeat count, branch trace, interrupt
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`default_nettype none
// Functional notes
// - two channels, each breaks alone when independent
// - sequential: A first, B in later cycle
// - address compare has per-bit mask
// - address source selectable, local or internal
// - 32-bit maskable data from selectable bus
// - cycle type, direction and size conditions
// - satisfied condition requests break exception
// - channel A fetch break before or after
// - channel B fetch break before or after
// - channel B repeat count up to 4095
// - four branch source/destination pairs
// - channel B internal-bus match flag sticks
// - trace enable gates branch recording
// - channel A data compare enable bit
// - reserved control bits read zero
module break_controller
    import break_controller_pkg::*;
(
    // clock, reset, enable
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    input  wire logic        i_ce,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // processor observation
    input  wire bus_cycle_s  i_cyc,
    input  wire branch_s     i_branch,
    // exception request and interrupt
    output break_s           o_break,
    output logic             o_irq
);
    typedef struct packed {
        chan_cfg_s                        cfg_a;
        chan_cfg_s                        cfg_b;
        logic                             seq_mode;
        logic                             pc_trace_enable;
        logic                             chan_a_fetch_break_timing;
        logic                             chan_b_fetch_break_timing;
        logic                             chan_b_ibus_match_flag;
        logic                             armed;
        logic [REP_W-1:0]                 rep_set;
        logic [REP_W-1:0]                 rep_cnt;
        logic [BRBUF_DEPTH-1:0][31:0]     br_src;
        logic [BRBUF_DEPTH-1:0][31:0]     br_dst;
        logic [1:0]                       br_ptr;
        logic [INT_W-1:0]                 int_status;
        logic [INT_W-1:0]                 int_mask;
        logic [31:0]                      rdata;
        break_s                           brk;
        logic                             irq;
    } state_s;

    localparam state_s ST_RESET = '0;

    state_s           st_reg;
    state_s           st_next;
    logic             match_a;
    logic             match_b;
    logic             b_qual;
    logic             b_fire;
    logic             a_fire;
    logic             wr_ctrl;
    logic             rd_stat;
    logic [INT_W-1:0] events;
    logic [31:0]      rd_val;
    logic [31:0]      ctrl_val;

    chan_match u_chan_a (
        .i_cfg   (st_reg.cfg_a),
        .i_cyc   (i_cyc),
        .o_match (match_a)
    );

    chan_match u_chan_b (
        .i_cfg   (st_reg.cfg_b),
        .i_cyc   (i_cyc),
        .o_match (match_b)
    );

    function automatic chan_cfg_s cyc_write(chan_cfg_s c, logic [31:0] w, logic keep_den);
        chan_cfg_s r;
        r         = c;
        r.ctype   = w[CYC_CTYPE_LSB +: 2];
        r.dir     = w[CYC_DIR_LSB +: 2];
        r.size    = w[CYC_SIZE_LSB +: 2];
        r.asrc    = w[CYC_ASRC_BIT];
        r.dsrc    = w[CYC_DSRC_BIT];
        // channel A takes its data enable from the control register instead
        r.data_en = keep_den ? c.data_en : w[CYC_DATA_EN_BIT];
        return r;
    endfunction

    function automatic logic [31:0] cyc_read(chan_cfg_s c, logic show_den);
        logic [31:0] r;
        r                        = 32'h0000_0000;
        r[CYC_CTYPE_LSB +: 2]    = c.ctype;
        r[CYC_DIR_LSB +: 2]      = c.dir;
        r[CYC_SIZE_LSB +: 2]     = c.size;
        r[CYC_ASRC_BIT]          = c.asrc;
        r[CYC_DSRC_BIT]          = c.dsrc;
        r[CYC_DATA_EN_BIT]       = show_den & c.data_en;
        return r;
    endfunction

    always_comb begin
        st_next = st_reg;
        wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
        rd_stat = i_rd && (i_addr == ADDR_INT_STAT);

        // control register image; bits 9 and 8 stay zero
        ctrl_val                  = 32'h0000_0000;
        ctrl_val[CTRL_SEQ_BIT]    = st_reg.seq_mode;
        ctrl_val[CTRL_TIMING_B]   = st_reg.chan_b_fetch_break_timing;
        ctrl_val[CTRL_DATA_EN_A]  = st_reg.cfg_a.data_en;
        ctrl_val[CTRL_TIMING_A]   = st_reg.chan_a_fetch_break_timing;
        ctrl_val[CTRL_TRACE_BIT]  = st_reg.pc_trace_enable;
        ctrl_val[CTRL_FLAG_B_BIT] = st_reg.chan_b_ibus_match_flag;

        // break sequencing; armed is last cycle's state so an A match cannot qualify B in the same cycle
        a_fire = !st_reg.seq_mode && match_a;
        b_qual = match_b && (!st_reg.seq_mode || st_reg.armed);
        b_fire = 1'b0;
        if (b_qual) begin
            if (st_reg.rep_set == '0) begin
                b_fire = 1'b1;
            end else if (st_reg.rep_cnt + 12'h001 == st_reg.rep_set) begin
                b_fire          = 1'b1;
                st_next.rep_cnt = '0;
            end else begin
                st_next.rep_cnt = st_reg.rep_cnt + 12'h001;
            end
        end
        if (st_reg.seq_mode && match_a) begin
            st_next.armed = 1'b1;
        end
        if (b_fire || !st_reg.seq_mode) begin
            st_next.armed = 1'b0;
        end

        // one-cycle request; data-access breaks always land after the access
        st_next.brk.req    = a_fire || b_fire;
        st_next.brk.chan_b = b_fire && !a_fire;
        if (a_fire) begin
            st_next.brk.after = !i_cyc.fetch || st_reg.chan_a_fetch_break_timing;
        end else begin
            st_next.brk.after = !i_cyc.fetch || st_reg.chan_b_fetch_break_timing;
        end

        // branch trace ring
        if (st_reg.pc_trace_enable && i_branch.valid) begin
            st_next.br_src[st_reg.br_ptr] = i_branch.src;
            st_next.br_dst[st_reg.br_ptr] = i_branch.dst;
            st_next.br_ptr                = st_reg.br_ptr + 2'h1;
        end

        // register writes
        if (i_wr) begin
            case (i_addr)
                ADDR_A_ADDR:   st_next.cfg_a.addr  = i_wdata;
                ADDR_A_AMASK:  st_next.cfg_a.amask = i_wdata;
                ADDR_A_DATA:   st_next.cfg_a.data  = i_wdata;
                ADDR_A_DMASK:  st_next.cfg_a.dmask = i_wdata;
                ADDR_A_CYCLE:  st_next.cfg_a = cyc_write(st_reg.cfg_a, i_wdata, 1'b1);
                ADDR_B_ADDR:   st_next.cfg_b.addr  = i_wdata;
                ADDR_B_AMASK:  st_next.cfg_b.amask = i_wdata;
                ADDR_B_DATA:   st_next.cfg_b.data  = i_wdata;
                ADDR_B_DMASK:  st_next.cfg_b.dmask = i_wdata;
                ADDR_B_CYCLE:  st_next.cfg_b = cyc_write(st_reg.cfg_b, i_wdata, 1'b0);
                ADDR_CTRL: begin
                    st_next.seq_mode                  = i_wdata[CTRL_SEQ_BIT];
                    st_next.chan_b_fetch_break_timing = i_wdata[CTRL_TIMING_B];
                    st_next.cfg_a.data_en             = i_wdata[CTRL_DATA_EN_A];
                    st_next.chan_a_fetch_break_timing = i_wdata[CTRL_TIMING_A];
                    st_next.pc_trace_enable           = i_wdata[CTRL_TRACE_BIT];
                end
                ADDR_REP_SET: begin
                    st_next.rep_set = i_wdata[REP_W-1:0];
                    st_next.rep_cnt = '0;
                end
                ADDR_INT_MASK: st_next.int_mask = i_wdata[INT_W-1:0];
                default: ;
            endcase
        end

        // match flag: writing 0 clears, writing 1 keeps, a new match wins
        st_next.chan_b_ibus_match_flag =
            (st_reg.chan_b_ibus_match_flag && !(wr_ctrl && !i_wdata[CTRL_FLAG_B_BIT]))
            || (match_b && i_cyc.on_ibus);

        // sticky interrupt status cleared by its read; new events win
        events              = '0;
        events[INT_BREAK_A] = a_fire;
        events[INT_BREAK_B] = b_fire;
        events[INT_FLAG_B]  = match_b && i_cyc.on_ibus;
        st_next.int_status  = (rd_stat ? '0 : st_reg.int_status) | events;
        st_next.irq         = |(st_next.int_status & st_next.int_mask);

        // read data, valid in the following cycle only
        rd_val = 32'h0000_0000;
        case (i_addr)
            ADDR_A_ADDR:   rd_val = st_reg.cfg_a.addr;
            ADDR_A_AMASK:  rd_val = st_reg.cfg_a.amask;
            ADDR_A_DATA:   rd_val = st_reg.cfg_a.data;
            ADDR_A_DMASK:  rd_val = st_reg.cfg_a.dmask;
            ADDR_A_CYCLE:  rd_val = cyc_read(st_reg.cfg_a, 1'b0);
            ADDR_B_ADDR:   rd_val = st_reg.cfg_b.addr;
            ADDR_B_AMASK:  rd_val = st_reg.cfg_b.amask;
            ADDR_B_DATA:   rd_val = st_reg.cfg_b.data;
            ADDR_B_DMASK:  rd_val = st_reg.cfg_b.dmask;
            ADDR_B_CYCLE:  rd_val = cyc_read(st_reg.cfg_b, 1'b1);
            ADDR_CTRL:     rd_val = ctrl_val;
            ADDR_REP_SET:  rd_val = {20'h00000, st_reg.rep_set};
            ADDR_REP_CNT:  rd_val = {20'h00000, st_reg.rep_cnt};
            ADDR_INT_STAT: rd_val = {29'h0000000, st_reg.int_status};
            ADDR_INT_MASK: rd_val = {29'h0000000, st_reg.int_mask};
            default: begin
                if (i_addr[7:6] == ADDR_BRBUF_HI && i_addr[5] == 1'b0) begin
                    rd_val = i_addr[2] ? st_reg.br_dst[i_addr[4:3]]
                                       : st_reg.br_src[i_addr[4:3]];
                end
            end
        endcase
        st_next.rdata = i_rd ? rd_val : 32'h0000_0000;
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            st_reg <= ST_RESET;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_break = st_reg.brk;
    assign o_irq   = st_reg.irq;

    // a channel A hit in independent mode raises a request next cycle
    property p_indep_a;
        @(posedge i_mclk) disable iff (i_srst)
        (i_ce && !st_reg.seq_mode && match_a) |=> (o_break.req && !o_break.chan_b);
    endproperty
    a_indep_a: assert property (p_indep_a)
        else $error("independent channel A match gave no break");

    // same-cycle A and B with nothing armed never breaks in sequential mode
    property p_seq_same;
        @(posedge i_mclk) disable iff (i_srst)
        (i_ce && st_reg.seq_mode && !st_reg.armed) |=> !o_break.req;
    endproperty
    a_seq_same: assert property (p_seq_same)
        else $error("sequential break without prior channel A match");

    // fetch break timing of channel A follows its control bit
    property p_timing_a;
        @(posedge i_mclk) disable iff (i_srst)
        (i_ce && a_fire && i_cyc.fetch)
            |=> (o_break.after == $past(st_reg.chan_a_fetch_break_timing));
    endproperty
    a_timing_a: assert property (p_timing_a)
        else $error("channel A fetch break timing wrong");

    // fetch break timing of channel B follows its control bit
    property p_timing_b;
        @(posedge i_mclk) disable iff (i_srst)
        (i_ce && b_fire && !a_fire && i_cyc.fetch)
            |=> (o_break.after == $past(st_reg.chan_b_fetch_break_timing));
    endproperty
    a_timing_b: assert property (p_timing_b)
        else $error("channel B fetch break timing wrong");

    // the repeat counter stays below a nonzero setting
    property p_repeat;
        @(posedge i_mclk) disable iff (i_srst)
        (st_reg.rep_set != '0) |-> (st_reg.rep_cnt < st_reg.rep_set);
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("repeat counter reached its setting");

    // an internal-bus match of channel B sets the flag even against a clear
    property p_flag_set;
        @(posedge i_mclk) disable iff (i_srst)
        (i_ce && match_b && i_cyc.on_ibus) |=> st_reg.chan_b_ibus_match_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("channel B internal match flag not set");

    // branches are not recorded while trace is off
    property p_trace_off;
        @(posedge i_mclk) disable iff (i_srst)
        (i_ce && !st_reg.pc_trace_enable) |=> $stable(st_reg.br_ptr);
    endproperty
    a_trace_off: assert property (p_trace_off)
        else $error("branch recorded with trace disabled");

    // reserved control bits read back as zero
    property p_reserved;
        @(posedge i_mclk) disable iff (i_srst)
        (i_ce && i_rd && i_addr == ADDR_CTRL) |=> (o_rdata[9:8] == 2'h0);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved control bits read nonzero");

    // with data compare on, a channel A match carries the masked data value
    property p_data_en_a;
        @(posedge i_mclk) disable iff (i_srst)
        (st_reg.cfg_a.data_en && match_a)
            |-> ((((st_reg.cfg_a.dsrc ? i_cyc.internal_data_bus : i_cyc.local_data_bus)
                 ^ st_reg.cfg_a.data) & ~st_reg.cfg_a.dmask) == 32'h0000_0000);
    endproperty
    a_data_en_a: assert property (p_data_en_a)
        else $error("channel A matched on the wrong data");

    // interrupt level always agrees with the registered status and mask
    property p_irq_level;
        @(posedge i_mclk) disable iff (i_srst)
        o_irq == |(st_reg.int_status & st_reg.int_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level disagrees with status and mask");

    // a recorded branch advances the ring by one entry
    property p_trace_rec;
        @(posedge i_mclk) disable iff (i_srst)
        (i_ce && st_reg.pc_trace_enable && i_branch.valid)
            |=> (st_reg.br_ptr == $past(st_reg.br_ptr) + 2'h1);
    endproperty
    a_trace_rec: assert property (p_trace_rec)
        else $error("branch ring pointer did not advance");

    // the flag rises only from a channel B match on the internal bus
    property p_flag_cause;
        @(posedge i_mclk) disable iff (i_srst)
        (i_ce && !st_reg.chan_b_ibus_match_flag && !(match_b && i_cyc.on_ibus))
            |=> !st_reg.chan_b_ibus_match_flag;
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("channel B match flag set without an internal bus match");

endmodule
`default_nettype wire

// *** verification/cpu_bus_model.sv ***
// processor side model: drives observed bus cycles and taken branches
`default_nettype none
module cpu_bus_model
    import break_controller_pkg::*;
(
    // clock
    input  wire logic      i_mclk,
    // observed traffic
    output var bus_cycle_s o_cyc,
    output var branch_s    o_branch
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_cyc = '0;
        o_branch = '0;
    end

    // a released bus shows inverted values, so a stale match cannot slip through
    task automatic cycle(input bus_cycle_s c);
        bus_cycle_s idle;
        idle = ~c;
        idle.valid = 1'b0;
        @(posedge i_mclk);
        o_cyc <= c;
        @(posedge i_mclk);
        o_cyc <= idle;
    endtask

    task automatic branch(input logic [31:0] s, input logic [31:0] d);
        @(posedge i_mclk);
        o_branch <= '{1'b1, s, d};
        @(posedge i_mclk);
        o_branch <= '{1'b0, ~s, ~d};
    endtask
endmodule
`default_nettype wire

// *** verification/break_controller_bench.sv ***
// self-checking bench of the break controller
`default_nettype none
module break_controller_bench;
    import break_controller_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_mclk;
    logic        i_srst;
    logic        i_ce;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic [31:0] o_rdata;
    bus_cycle_s  i_cyc;
    branch_s     i_branch;
    break_s      o_break;
    logic        o_irq;
    int          bad_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [31:0] seed;
    logic [31:0] ra;
    logic [31:0] rb;
    logic [31:0] dv;

    break_controller dut (.i_mclk, .i_srst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_cyc, .i_branch, .o_break, .o_irq);
    cpu_bus_model model (.i_mclk(i_mclk), .o_cyc(i_cyc), .o_branch(i_branch));

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    // a hang ends the run as a failure instead of running forever
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            results();
        end
    end

    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // address and data sources are set together to keep the table short
    function automatic logic [31:0] cfg(logic [1:0] ct, logic [1:0] dr, logic [1:0] sz,
        logic src, logic den);
        return {23'h0, den, src, src, sz, dr, ct};
    endfunction

    // the bus not carrying the cycle holds the inverse
    function automatic bus_cycle_s mk(logic f, logic w, logic [1:0] sz, logic ib,
        logic [31:0] a, logic [31:0] d);
        return '{1'b1, ib, f, w, sz, ib ? ~a : a, ib ? a : ~a, ib ? ~d : d, ib ? d : ~d};
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask

    // exp is {req, after, chan_b}; fields are ignored when no request is seen
    task automatic brk(input bus_cycle_s c, input logic [2:0] exp);
        model.cycle(c);
        #1;
        chk({29'h0, 3'(o_break) & {3{o_break.req}}}, {29'h0, exp});
    endtask

    initial begin
        seed = 32'hb99c;
        i_srst = 1'b1;
        i_ce = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        repeat (20) @(posedge i_mclk);
        i_srst <= 1'b0;
        rdx(ADDR_CTRL, 32'h0);
        rdx(ADDR_INT_STAT, 32'h0);
        // every writable bit set, reserved bits 9 and 8 kept at zero
        wr(ADDR_CTRL, 32'hfffffcff);
        rdx(ADDR_CTRL, 32'h0cc1);
        wr(8'h3c, 32'hffffffff);
        rdx(8'h3c, 32'h0);
        ra = lfsr();
        wr(ADDR_A_ADDR, ra);
        wr(ADDR_A_AMASK, 32'hff);
        wr(ADDR_A_CYCLE, cfg(CTYPE_FETCH, DIR_READ, SIZE_ANY, 1'b0, 1'b0));
        for (int t = 0; t < 2; t++) begin
            wr(ADDR_CTRL, 32'(t) << CTRL_TIMING_A);
            brk(mk(1, 0, SIZE_LONG, 0, ra ^ (lfsr() & 32'hff), 0), t ? 3'h6 : 3'h4);
        end
        brk(mk(1, 0, SIZE_LONG, 0, ra ^ 32'h100, 0), 3'h0);
        brk(mk(1, 1, SIZE_LONG, 0, ra, 0), 3'h0);
        brk(mk(0, 0, SIZE_LONG, 0, ra, 0), 3'h0);
        brk(mk(1, 0, SIZE_LONG, 1, ra, 0), 3'h0);
        wr(ADDR_A_CYCLE, cfg(CTYPE_FETCH, DIR_READ, SIZE_WORD, 1'b0, 1'b0));
        brk(mk(1, 0, SIZE_LONG, 0, ra, 0), 3'h0);
        brk(mk(1, 0, SIZE_WORD, 0, ra, 0), 3'h6);
        dv = lfsr();
        wr(ADDR_A_DATA, dv);
        wr(ADDR_A_CYCLE, cfg(CTYPE_DATA, DIR_WRITE, SIZE_ANY, 1'b0, 1'b0));
        wr(ADDR_CTRL, 32'h1 << CTRL_DATA_EN_A);
        brk(mk(0, 1, SIZE_BYTE, 0, ra, dv), 3'h6);
        brk(mk(0, 1, SIZE_BYTE, 0, ra, ~dv), 3'h0);
        chk(32'(o_irq), 32'h0);
        wr(ADDR_INT_MASK, 32'h1);
        wr(ADDR_CTRL, 32'h0);
        brk(mk(0, 1, SIZE_BYTE, 0, ra, ~dv), 3'h6);
        @(posedge i_mclk);
        #1;
        chk(32'(o_irq), 32'h1);
        rdx(ADDR_INT_STAT, 32'h1);
        repeat (2) @(posedge i_mclk);
        #1;
        chk(32'(o_irq), 32'h0);
        wr(ADDR_A_CYCLE, 32'h0);
        rb = lfsr();
        wr(ADDR_B_ADDR, rb);
        wr(ADDR_B_DATA, dv);
        wr(ADDR_B_DMASK, 32'hffff0000);
        wr(ADDR_B_CYCLE, cfg(CTYPE_FETCH, DIR_READ, SIZE_ANY, 1'b1, 1'b1));
        wr(ADDR_CTRL, 32'h1 << CTRL_TIMING_B);
        brk(mk(1, 0, SIZE_WORD, 1, rb, dv ^ 32'h5a5a0000), 3'h7);
        // a matching cycle seen while the enable is low must leave no trace
        @(posedge i_mclk);
        i_ce <= 1'b0;
        brk(mk(1, 0, SIZE_WORD, 1, rb, dv), 3'h0);
        @(posedge i_mclk);
        i_ce <= 1'b1;
        brk(mk(1, 0, SIZE_WORD, 1, rb, dv ^ 32'h1), 3'h0);
        brk(mk(1, 0, SIZE_WORD, 0, rb, dv), 3'h0);
        rdx(ADDR_CTRL, 32'h1040);
        wr(ADDR_CTRL, 32'h40);
        rdx(ADDR_CTRL, 32'h40);
        rdx(ADDR_INT_STAT, 32'h6);
        // channel A also accepts rb so one cycle can satisfy both channels
        wr(ADDR_A_AMASK, ra ^ rb);
        wr(ADDR_A_CYCLE, cfg(CTYPE_FETCH, DIR_READ, SIZE_ANY, 1'b0, 1'b0));
        wr(ADDR_B_CYCLE, cfg(CTYPE_FETCH, DIR_READ, SIZE_ANY, 1'b0, 1'b0));
        wr(ADDR_CTRL, 32'h1);
        brk(mk(1, 0, SIZE_BYTE, 0, rb, 0), 3'h0);
        brk(mk(1, 0, SIZE_BYTE, 0, rb, 0), 3'h5);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        brk(mk(1, 0, SIZE_BYTE, 0, ra, 0), 3'h0);
        brk(mk(1, 0, SIZE_BYTE, 0, rb, 0), 3'h5);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_A_CYCLE, 32'h0);
        wr(ADDR_REP_SET, 32'hffffffff);
        rdx(ADDR_REP_SET, 32'hfff);
        wr(ADDR_REP_SET, 32'h3);
        for (int k = 1; k <= 6; k++)
            brk(mk(1, 0, SIZE_BYTE, 0, rb, 0), k % 3 == 0 ? 3'h5 : 3'h0);
        model.branch(ra, rb);
        rdx(8'h40, 32'h0);
        wr(ADDR_CTRL, 32'h1 << CTRL_TRACE_BIT);
        for (int i = 0; i < 4; i++)
            model.branch(ra + i, rb + i);
        for (int i = 0; i < 4; i++) begin
            rdx(8'h40 + 8'(8 * i), ra + i);
            rdx(8'h44 + 8'(8 * i), rb + i);
        end
        results();
    end
endmodule
`default_nettype wire
